// ---- common/uft_pkg.sv ----
/*
 * Package of the USB frame timing block: register offsets, field
 * positions, reset values, the bit-time rate and the carrier structs.
 * Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
 */
package uft_pkg;

    // System clock and bit-time rate
    localparam int unsigned UFT_CLK_HZ = 100_000_000; // System clock rate
    localparam int unsigned UFT_BIT_HZ = 12_000_000;  // Full-speed bit rate
    localparam int unsigned UFT_RATE_UNIT = 1_000_000; // Common divisor of both
    localparam logic [7:0] UFT_TICK_NUM = 8'(UFT_BIT_HZ / UFT_RATE_UNIT); // 12
    localparam logic [7:0] UFT_TICK_DEN = 8'(UFT_CLK_HZ / UFT_RATE_UNIT); // 100

    // Register byte addresses
    localparam logic [7:0] UFT_OFS_DONE_HEAD = 8'h00; // done_queue_head_pointer
    localparam logic [7:0] UFT_OFS_INTERVAL = 8'h04;  // frame_interval_config
    localparam logic [7:0] UFT_OFS_REMAINING = 8'h08; // frame_remaining_count
    localparam logic [7:0] UFT_OFS_NUMBER = 8'h0c;    // frame_number_count
    localparam logic [7:0] UFT_OFS_PERIODIC = 8'h10;  // periodic_start_position
    localparam logic [7:0] UFT_OFS_CONTROL = 8'h14;   // Run control and status

    // Field positions
    localparam int unsigned UFT_HEAD_LSB = 4; // Done head address low bit
    localparam int unsigned UFT_ITOG_BIT = 31; // interval_toggle
    localparam int unsigned UFT_PKT_LSB = 16; // max_full_speed_packet low bit
    localparam int unsigned UFT_PKT_MSB = 30; // max_full_speed_packet high bit
    localparam int unsigned UFT_LEN_MSB = 13; // 14-bit frame fields top bit
    localparam int unsigned UFT_RTOG_BIT = 31; // remaining_toggle
    localparam int unsigned UFT_NUM_MSB = 15; // Frame number top bit
    localparam int unsigned UFT_RUN_BIT = 0;     // Control: run
    localparam int unsigned UFT_PRIO_BIT = 1;    // Control: periodic priority
    localparam int unsigned UFT_LSOK_BIT = 2;    // Control: low-speed allowed
    localparam int unsigned UFT_EMPTY_BIT = 3;   // Control: done queue empty

    // Reset values
    localparam logic [13:0] UFT_LEN_RESET = 14'h2edf; // Nominal 1 ms frame
    localparam logic [14:0] UFT_PKT_RESET = 15'h0000; // Packet limit
    localparam logic [13:0] UFT_PRIO_PT_RESET = 14'h0000; // Periodic start
    localparam logic [27:0] UFT_HEAD_RESET = 28'h0000000; // Empty done queue
    localparam logic [15:0] UFT_NUM_RESET = 16'h0000; // Frame number

    // Frame number post to the shared communication area
    typedef struct packed {
        logic valid;               // Post pending
        logic [15:0] frame_number; // New frame number
    } uft_comm_wr_t;

    // Completed descriptor report from list processing
    typedef struct packed {
        logic valid;        // Descriptor appended to done queue
        logic [31:0] addr;  // Its physical address
    } uft_retire_t;

endpackage : uft_pkg

// ---- dv/uft_frame_timer_checker.sv ----
/* Checker for uft_frame_timer: bus, frame post and tick timing.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timer_checker
    import uft_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Ack
    input wire uft_comm_wr_t comm_wr_o, // Post
    input wire logic comm_wr_ready_i, // Post accept
    input wire logic sof_status_o, // Frame start
    input wire logic list_start_o, // List start
    input wire logic periodic_priority_o, // Priority
    input wire logic bit_tick_o // Bit tick
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] last_num_q; // Last accepted frame number
    // Track the number of each accepted post
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_num_q <= 16'h0000;
        end else if (comm_wr_o.valid && comm_wr_ready_i) begin
            last_num_q <= comm_wr_o.frame_number;
        end
    end
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data not zero outside ack");
    chk_sof_list: assert property (sof_status_o |-> list_start_o ##1 !sof_status_o)
        else $error("frame start and list start differ");
    chk_sof_after_post: assert property (comm_wr_o.valid && comm_wr_ready_i
        |-> ##2 sof_status_o)
        else $error("frame start not after accepted post");
    chk_post_hold: assert property (comm_wr_o.valid && !comm_wr_ready_i
        |=> comm_wr_o.valid && $stable(comm_wr_o.frame_number))
        else $error("post dropped or changed before accept");
    chk_post_number: assert property ($rose(comm_wr_o.valid)
        |-> comm_wr_o.frame_number == 16'(last_num_q + 16'h0001))
        else $error("posted frame number not previous plus one");
    chk_tick_spacing: assert property (bit_tick_o |=> !bit_tick_o [*7])
        else $error("bit ticks closer than eight clocks");
    chk_prio_clear: assert property ($rose(comm_wr_o.valid) |-> !periodic_priority_o)
        else $error("priority still set after reload");
endmodule : uft_frame_timer_checker
bind uft_frame_timer uft_frame_timer_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comm_wr_o(comm_wr_o), .comm_wr_ready_i(comm_wr_ready_i), .sof_status_o(sof_status_o),
    .list_start_o(list_start_o), .periodic_priority_o(periodic_priority_o),
    .bit_tick_o(bit_tick_o));
`default_nettype wire

// ---- dv/uft_frame_timer_tb.sv ----
/* Self-checking testbench for uft_frame_timer over classic Wishbone.
   Assumes a 100 MHz clock; short frame lengths keep the run brief. */
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timer_tb;
    import uft_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus and clock
    logic [7:0] adr = 8'h00; // Address
    logic [3:0] sel = 4'hf; // Byte lanes
    logic [31:0] wdat = 32'h00000000, rdat, q; // Data
    logic ack, head_clr = 1'b0, ready = 1'b1, sof, lstart, prio, lso, tick; // Misc
    logic [13:0] cutoff = 14'h3fff; // Low-speed threshold
    logic [14:0] mfsp; // Packet limit
    uft_retire_t retire = '0; // Retire report
    uft_comm_wr_t post; // Post request
    int error_cnt = 0, check_count = 0, cycles = 0; // Counters
    always #5 clk_i = ~clk_i; // 100 MHz
    uft_frame_timer u_uft_frame_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .retire_i(retire), .done_head_clear_i(head_clr),
        .slow_packet_cutoff_i(cutoff), .comm_wr_o(post), .comm_wr_ready_i(ready),
        .sof_status_o(sof), .list_start_o(lstart), .periodic_priority_o(prio),
        .low_speed_ok_o(lso), .max_full_speed_packet_o(mfsp), .bit_tick_o(tick));
    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask : wb
    // Wait for a frame start pulse
    task automatic wait_sof;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (sof !== 1'b1 && n < 400);
        check(32'(lstart), 32'h1);
    endtask : wait_sof
    // Register values after reset, unmapped place
    task automatic t_reset;
        wb(1'b0, UFT_OFS_DONE_HEAD, 0);
        check(q, 32'h0);
        wb(1'b0, UFT_OFS_INTERVAL, 0);
        check(q, {18'h0, UFT_LEN_RESET});
        wb(1'b0, UFT_OFS_REMAINING, 0);
        check(q, 32'h0);
        wb(1'b0, UFT_OFS_NUMBER, 0);
        check(q, 32'h0);
        wb(1'b0, UFT_OFS_CONTROL, 0);
        check(q, 32'h8);
        wb(1'b1, 8'h20, 32'hffffffff);
        wb(1'b0, 8'h20, 0);
        check(q, 32'h0);
    endtask : t_reset
    // Done head: hardware update, read-only, clear, retire beats clear
    task automatic t_done;
        wb(1'b1, UFT_OFS_DONE_HEAD, 32'hfffffff0);
        wb(1'b0, UFT_OFS_DONE_HEAD, 0);
        check(q, 32'h0);
        @(posedge clk_i) retire <= '{1'b1, 32'habcd123f};
        @(posedge clk_i) retire.valid <= 1'b0;
        wb(1'b0, UFT_OFS_DONE_HEAD, 0);
        check(q, 32'habcd1230);
        wb(1'b0, UFT_OFS_CONTROL, 0);
        check(q, 32'h0);
        @(posedge clk_i) head_clr <= 1'b1;
        @(posedge clk_i) head_clr <= 1'b0;
        wb(1'b0, UFT_OFS_DONE_HEAD, 0);
        check(q, 32'h0);
        @(posedge clk_i) begin
            retire <= '{1'b1, 32'h00000040};
            head_clr <= 1'b1;
        end
        @(posedge clk_i) begin
            retire.valid <= 1'b0;
            head_clr <= 1'b0;
        end
        wb(1'b0, UFT_OFS_DONE_HEAD, 0);
        check(q, 32'h40);
    endtask : t_done
    // First frame: slow post accept, toggle copy, read-only remaining
    task automatic t_first;
        int n;
        wb(1'b1, UFT_OFS_INTERVAL, 32'h80050010);
        wb(1'b0, UFT_OFS_INTERVAL, 0);
        check(q, 32'h80050010);
        check(32'(mfsp), 32'h5);
        wb(1'b1, UFT_OFS_PERIODIC, 32'h8);
        wb(1'b0, UFT_OFS_PERIODIC, 0);
        check(q, 32'h8);
        ready <= 1'b0;
        wb(1'b1, UFT_OFS_CONTROL, 32'h1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (post.valid !== 1'b1 && n < 50);
        repeat (3) @(posedge clk_i);
        check(32'(post.valid), 32'h1);
        check(32'(post.frame_number), 32'h1);
        ready <= 1'b1;
        wait_sof();
        check(32'(lso), 32'h0);
        wb(1'b1, UFT_OFS_REMAINING, 32'h0);
        wb(1'b0, UFT_OFS_REMAINING, 0);
        check(32'(q[31]), 32'h1);
        wb(1'b0, UFT_OFS_NUMBER, 0);
        check(q, 32'h1);
    endtask : t_first
    // Frame length, priority, low-speed edge and toggle after an interval change
    task automatic t_length(input logic tog, input logic [13:0] flen, input logic [31:0] num);
        int ticks;
        logic seen_prio;
        ticks = 0;
        seen_prio = 1'b0;
        cutoff <= flen;
        wb(1'b1, UFT_OFS_INTERVAL, {tog, 15'h5, 2'b00, flen});
        wait_sof();
        check(32'(prio), 32'h0);
        check(32'(lso), 32'h0);
        cutoff <= flen - 14'h0001;
        @(posedge clk_i);
        check(32'(lso), 32'h1);
        do begin
            @(posedge clk_i);
            if (tick === 1'b1) ticks++;
            if (prio === 1'b1) seen_prio = 1'b1;
        end while (sof !== 1'b1 && ticks < 40);
        check(ticks, 32'(flen) + 32'h1);
        check(32'(seen_prio), 32'h1);
        wb(1'b0, UFT_OFS_REMAINING, 0);
        check(32'(q[31]), 32'(tog));
        wb(1'b0, UFT_OFS_NUMBER, 0);
        check(q, num);
    endtask : t_length
    // Nominal 1 ms interval written with a flipped toggle and read back
    task automatic t_nominal;
        wb(1'b1, UFT_OFS_INTERVAL, 32'h00052edf);
        wb(1'b0, UFT_OFS_INTERVAL, 0);
        check(q, 32'h00052edf);
    endtask : t_nominal
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_done();
        t_first();
        t_length(1'b0, 14'h0012, 32'h3);
        t_length(1'b1, 14'h0010, 32'h5);
        t_nominal();
        final_report();
    end
endmodule : uft_frame_timer_tb
`default_nettype wire

// ---- logic/uft_frame_timer.sv ----
/*
 * USB full-speed frame timer with done queue head pointer, reached over
 * classic Wishbone. Assumes list processing reports retired descriptors
 * on this clock and a memory agent accepts frame number posts.
 */
// Decided for this implementation: the address map and the Wishbone register port.
// How it works
// - Done head keeps address bits 31..4
// - Hardware updates done head; software read-only
// - Zero done head means queue empty
// - Fourteen-bit interval sets bit clocks per frame
// - Fifteen-bit max full-speed packet field
// - Remaining field reports bit times, read-only
// - Remaining counter reloads from interval each frame
// - Reload copies interval toggle to remaining toggle
// - Frame number increments on reload, wraps
// - Post number, raise start status, start lists
// - Control/bulk first, periodic after start point
// - Low-speed start only above threshold
`timescale 1ns/1ps
`default_nettype none
module uft_frame_timer
    import uft_pkg::*;
(
    input wire logic clk_i,                    // 100 MHz system clock
    input wire logic rst_i,                    // Asynchronous reset, active high
    input wire logic wb_cyc_i,                 // Wishbone cycle
    input wire logic wb_stb_i,                 // Wishbone strobe
    input wire logic wb_we_i,                  // Wishbone write enable
    input wire logic [7:0] wb_adr_i,           // Wishbone byte address
    input wire logic [3:0] wb_sel_i,           // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,          // Wishbone write data
    output logic [31:0] wb_dat_o,              // Wishbone read data
    output logic wb_ack_o,                     // Wishbone acknowledge
    input wire uft_retire_t retire_i,          // Descriptor appended to done queue
    input wire logic done_head_clear_i,        // Done queue handed to software
    input wire logic [13:0] slow_packet_cutoff_i, // Low-speed threshold
    output uft_comm_wr_t comm_wr_o,            // Frame number post request
    input wire logic comm_wr_ready_i,          // Post accepted
    output logic sof_status_o,                 // Start-of-frame status pulse
    output logic list_start_o,                 // Begin descriptor lists pulse
    output logic periodic_priority_o,          // Periodic lists have priority
    output logic low_speed_ok_o,               // Low-speed start allowed
    output logic [14:0] max_full_speed_packet_o, // Packet size limit, bit times
    output logic bit_tick_o                    // Full-speed bit-time enable
);

    // Frame start sequence states
    typedef enum logic [1:0] {
        UFT_SEQ_IDLE,   // Waiting for a frame boundary
        UFT_SEQ_POST,   // Posting frame number to memory
        UFT_SEQ_SIGNAL  // Raising status and starting lists
    } uft_seq_t;

    // Registers
    logic [27:0] done_head_address_q;   // Done queue head, bits 31..4
    logic [27:0] done_head_address_d;   // Next done head
    logic interval_toggle_q;            // Interval toggle as written
    logic [14:0] max_full_speed_packet_q; // Packet size limit
    logic [13:0] frame_length_value_q;  // Bit clocks per frame minus one
    logic remaining_toggle_q;           // Toggle copied at reload
    logic [13:0] bit_times_left_q;      // Remaining bit times
    logic [13:0] bit_times_left_d;      // Next remaining count
    logic [15:0] frame_counter_value_q; // Frame number
    logic [13:0] periodic_priority_point_q; // Periodic start position
    logic run_q;                        // Frame generation enabled
    logic run_prev_q;                   // Run one cycle ago
    logic prio_q;                       // Periodic priority latch
    logic prio_d;                       // Next periodic priority
    logic ack_q;                        // Bus acknowledge
    logic [31:0] rdata_q;               // Registered read data
    uft_seq_t seq_q;                    // Frame start sequence state
    uft_seq_t seq_d;                    // Next sequence state
    logic [15:0] post_number_q;         // Number being posted
    logic sof_q;                        // Start-of-frame pulse
    logic list_q;                       // List start pulse

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;       // New access this cycle
    wire bus_wr = bus_req && wb_we_i;                    // Write access
    wire sel_interval = (wb_adr_i == UFT_OFS_INTERVAL);  // Interval register hit
    wire sel_periodic = (wb_adr_i == UFT_OFS_PERIODIC);  // Periodic start hit
    wire sel_control = (wb_adr_i == UFT_OFS_CONTROL);    // Control register hit
    wire wr_interval = bus_wr && sel_interval;           // Interval write
    wire wr_periodic = bus_wr && sel_periodic;           // Periodic start write
    wire wr_control = bus_wr && sel_control;             // Control write

    // Frame timing decode
    wire bit_tick;                                       // One bit time elapsed
    wire run_start = run_q && !run_prev_q;               // Generation just enabled
    wire count_expired = bit_tick && (bit_times_left_q == 14'h0000); // Frame end
    wire frame_reload = run_start || (run_q && count_expired); // New frame
    wire prio_reached = (bit_times_left_q <= periodic_priority_point_q);
    wire done_empty = (done_head_address_q == UFT_HEAD_RESET); // Queue empty

    // Register views
    wire [31:0] done_head_view = {done_head_address_q, 4'h0};
    wire [31:0] interval_view = {interval_toggle_q, max_full_speed_packet_q,
                                 2'b00, frame_length_value_q};
    wire [31:0] remaining_view = {remaining_toggle_q, 17'h00000,
                                  bit_times_left_q};
    wire [31:0] number_view = {16'h0000, frame_counter_value_q};
    wire [31:0] periodic_view = {18'h00000, periodic_priority_point_q};
    wire [31:0] control_view = {28'h0000000, done_empty, low_speed_ok_o,
                                prio_q, run_q};

    // Read data selection, unmapped offsets read zero
    logic [31:0] rdata_mux; // Selected register view
    always_comb begin
        case (wb_adr_i)
            UFT_OFS_DONE_HEAD: rdata_mux = done_head_view;
            UFT_OFS_INTERVAL: rdata_mux = interval_view;
            UFT_OFS_REMAINING: rdata_mux = remaining_view;
            UFT_OFS_NUMBER: rdata_mux = number_view;
            UFT_OFS_PERIODIC: rdata_mux = periodic_view;
            UFT_OFS_CONTROL: rdata_mux = control_view;
            default: rdata_mux = 32'h00000000;
        endcase
    end

    // Bit-time enable from the system clock
    uft_rate_tick #(
        .NUM(UFT_TICK_NUM),
        .DEN(UFT_TICK_DEN)
    ) u_bit_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_q),
        .tick_o(bit_tick)
    );

    // Bus slave: one-cycle acknowledge, data registered with it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            rdata_q <= bus_req ? rdata_mux : 32'h00000000;
        end
    end

    // Software-written configuration, byte lanes honoured
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            interval_toggle_q <= 1'b0;
            max_full_speed_packet_q <= UFT_PKT_RESET;
            frame_length_value_q <= UFT_LEN_RESET;
            periodic_priority_point_q <= UFT_PRIO_PT_RESET;
            run_q <= 1'b0;
        end else begin
            if (wr_interval) begin
                if (wb_sel_i[0]) frame_length_value_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) frame_length_value_q[13:8] <= wb_dat_i[13:8];
                if (wb_sel_i[2]) max_full_speed_packet_q[7:0] <= wb_dat_i[23:16];
                if (wb_sel_i[3]) begin
                    max_full_speed_packet_q[14:8] <= wb_dat_i[UFT_PKT_MSB:24];
                    interval_toggle_q <= wb_dat_i[UFT_ITOG_BIT];
                end
            end
            if (wr_periodic) begin
                if (wb_sel_i[0]) periodic_priority_point_q[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) periodic_priority_point_q[13:8] <= wb_dat_i[13:8];
            end
            if (wr_control && wb_sel_i[0]) begin
                run_q <= wb_dat_i[UFT_RUN_BIT];
            end
        end
    end

    // Done head: hardware-owned, a retire beats a same-cycle clear
    always_comb begin
        done_head_address_d = done_head_address_q;
        if (retire_i.valid) begin
            done_head_address_d = retire_i.addr[31:UFT_HEAD_LSB];
        end else if (done_head_clear_i) begin
            done_head_address_d = UFT_HEAD_RESET;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_head_address_q <= UFT_HEAD_RESET;
        end else begin
            done_head_address_q <= done_head_address_d;
        end
    end

    // Remaining count: reload at frame start, else one per bit time
    always_comb begin
        bit_times_left_d = bit_times_left_q;
        if (frame_reload) begin
            bit_times_left_d = frame_length_value_q;
        end else if (run_q && bit_tick) begin
            bit_times_left_d = bit_times_left_q - 14'h0001;
        end
    end

    // Periodic priority from start point to frame end
    always_comb begin
        if (frame_reload) begin
            prio_d = 1'b0;
        end else if (run_q && prio_reached) begin
            prio_d = 1'b1;
        end else begin
            prio_d = prio_q;
        end
    end

    // Frame counters
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_times_left_q <= 14'h0000;
            remaining_toggle_q <= 1'b0;
            frame_counter_value_q <= UFT_NUM_RESET;
            prio_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_q;
            bit_times_left_q <= bit_times_left_d;
            prio_q <= prio_d;
            if (frame_reload) begin
                remaining_toggle_q <= interval_toggle_q;
                frame_counter_value_q <= frame_counter_value_q + 16'h0001;
            end
        end
    end

    // Frame start sequence next state
    always_comb begin
        case (seq_q)
            UFT_SEQ_IDLE: begin
                seq_d = frame_reload ? UFT_SEQ_POST : UFT_SEQ_IDLE;
            end
            UFT_SEQ_POST: begin
                seq_d = comm_wr_ready_i ? UFT_SEQ_SIGNAL : UFT_SEQ_POST;
            end
            UFT_SEQ_SIGNAL: begin
                seq_d = UFT_SEQ_IDLE;
            end
            default: begin
                seq_d = UFT_SEQ_IDLE;
            end
        endcase
    end

    // Post number, then status and list start pulses
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_q <= UFT_SEQ_IDLE;
            post_number_q <= UFT_NUM_RESET;
            sof_q <= 1'b0;
            list_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            if (seq_q == UFT_SEQ_IDLE && frame_reload) begin
                post_number_q <= frame_counter_value_q + 16'h0001;
            end
            sof_q <= (seq_q == UFT_SEQ_SIGNAL);
            list_q <= (seq_q == UFT_SEQ_SIGNAL);
        end
    end

    // Outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign comm_wr_o = '{valid: (seq_q == UFT_SEQ_POST),
                         frame_number: post_number_q};
    assign sof_status_o = sof_q;
    assign list_start_o = list_q;
    assign periodic_priority_o = prio_q;
    assign low_speed_ok_o = run_q && (bit_times_left_q > slow_packet_cutoff_i);
    assign max_full_speed_packet_o = max_full_speed_packet_q;
    assign bit_tick_o = bit_tick;

endmodule : uft_frame_timer
`default_nettype wire

// ---- logic/uft_rate_tick.sv ----
/*
 * Fractional rate divider: one-cycle enable at NUM/DEN of the clock rate.
 * Assumes NUM < DEN and a free-running system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module uft_rate_tick #(
    parameter logic [7:0] NUM = 8'h0c, // Ticks per DEN clocks
    parameter logic [7:0] DEN = 8'h64  // Clock cycles per period
) (
    input wire logic clk_i,  // System clock
    input wire logic rst_i,  // Asynchronous reset, active high
    input wire logic run_i,  // Count only while high
    output logic tick_o      // One-cycle enable pulse
);
    logic [7:0] acc_q;   // Phase accumulator
    logic [7:0] sum;     // Accumulator plus step
    logic wrap;          // Period boundary crossed

    // Next phase and wrap decode
    assign sum = acc_q + NUM;
    assign wrap = run_i && (sum >= DEN);

    // Accumulate phase, emit a tick at each wrap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            tick_o <= wrap;
            if (!run_i) begin
                acc_q <= 8'h00;
            end else if (wrap) begin
                acc_q <= sum - DEN;
            end else begin
                acc_q <= sum;
            end
        end
    end
endmodule : uft_rate_tick
`default_nettype wire
